//--- src/fvcr_regs.sv
// Purpose: volatile read and enhanced configuration of a serial flash
// Assumes: instructions arrive single-line on data line zero, mode 0
// Notes:   pins are sampled by clk_sys_i through two flip-flops

`timescale 1ns/1ps

// What this block does
// - fast reads insert programmed dummy clock count
// - execute in place only when bit clear
// - basic variant ignores execute in place bit
// - reads confined to aligned 16/32/64 block
// - address increments, wraps to block start
// - wrap codes 00,01,10; 11 is sequential
// - each write replaces power-on loaded configuration
// - enhanced bit 7 low selects quad protocol
// - bit 6 low, bit 7 high: dual
// - both low gives quad priority
// - bit 7 high resumes extended or dual
// - protocol change effective right after write
// - bit 4 low ignores hold/reset pin
// - power-on re-enables hold unless nonvolatile says
// - accelerating voltage honoured only when bit 3 low
// - in quad protocol, extended commands accepted until voltage drops or the wait times out
// - voltage late beyond 200ms sets error flag
// - error flag stays until clear instruction
// - three-bit drive code, default 111
module fvcr_regs
	import fvcr_pkg::*;
#(
	parameter bit BASIC_XIP       = 1'b0,
	parameter int VPP_TIMEOUT_CYC = fvcr_pkg::FVCR_VPP_TIMEOUT_CYC
)
(
	input  wire logic              clk_sys_i,
	input  wire logic              sys_rst_i,
	input  wire logic              serial_clk_i,
	input  wire logic              chip_sel_n_i,
	input  wire logic              data_line_zero_i,
	input  wire logic              vpp_high_i,
	input  wire logic [15:0]       nonvolatile_config_i,
	input  wire logic              quad_modify_done_i,
	input  wire logic              rd_load_i,
	input  wire logic [23:0]       rd_addr_i,
	input  wire logic              rd_step_i,
	output logic [7:0]             volatile_read_config_o,
	output logic [7:0]             volatile_enhanced_config_o,
	output fvcr_pkg::fvcr_cfg_t    cfg_o,
	output logic                   ext_override_o,
	output logic                   vpp_error_o,
	output logic [23:0]            rd_addr_o
);
	import fvcr_pkg::*;

	localparam int TW = $clog2(VPP_TIMEOUT_CYC + 1);
	localparam logic [TW-1:0] TMO_LAST = TW'(VPP_TIMEOUT_CYC - 1);
	localparam logic [4:0] BITS_CMD  = 5'h08;
	localparam logic [4:0] BITS_WR   = 5'h10;
	localparam logic [4:0] BITS_SAT  = 5'h11;

	typedef struct packed {
		logic [2:0]  sclk;
		logic [2:0]  csn;
		logic [1:0]  din;
		logic [1:0]  vpp;
		logic [4:0]  bits;
		logic [15:0] shift;
		logic        loaded;
		logic [7:0]  rd_cfg;
		logic [7:0]  enh_cfg;
		fvcr_cfg_t   cfg;
		fvcr_vpp_t   vst;
		logic [TW-1:0] tmr;
		logic        ovr;
		logic        err;
		logic [23:0] addr;
	} fvcr_state_t;

	fvcr_state_t s_ff;
	fvcr_state_t nxt_s;

	logic        sclk_rise;
	logic        desel;
	logic        wr_rd;
	logic        wr_enh;
	logic        clr_fs;
	logic        tmo_hit;

	// ------------------------------------------------------------
	// Decoding helpers
	// ------------------------------------------------------------
	function automatic fvcr_proto_t proto_of(input logic [7:0] enh);
		// Quad wins when both enables are low
		if (!enh[FVCR_ENH_QUAD_BIT])
			return FVCR_PROTO_QUAD;
		else if (!enh[FVCR_ENH_DUAL_BIT])
			return FVCR_PROTO_DUAL;
		else
			return FVCR_PROTO_EXT;
	endfunction

	function automatic fvcr_cfg_t cfg_of(input logic [7:0] rd,
		input logic [7:0] enh);
		fvcr_cfg_t c;
		c = '0;
		// field zero behaves as the largest count
		c.dummy = (rd[7:4] == 4'h0) ? FVCR_DUMMY_MAX : rd[7:4];
		c.xip_allowed = BASIC_XIP | ~rd[FVCR_RD_XIP_BIT];
		c.wrap = rd[1:0];
		// fall back on bit 7 high
		c.proto = proto_of(enh);
		c.hold_en = enh[FVCR_ENH_HOLD_BIT];
		c.accel_en = ~enh[FVCR_ENH_ACC_BIT];
		c.drive = enh[2:0];
		return c;
	endfunction

	function automatic logic [23:0] wrap_next(input logic [23:0] a,
		input logic [1:0] w);
		logic [23:0] m;
		logic [23:0] inc;
		case (w)
			FVCR_WRAP_16: m = 24'h00000f;
			FVCR_WRAP_32: m = 24'h00001f;
			FVCR_WRAP_64: m = 24'h00003f;
			default:      m = 24'hffffff;
		endcase
		inc = a + 24'h000001;
		return (a & ~m) | (inc & m);
	endfunction

	// ------------------------------------------------------------
	// Next-state logic
	// ------------------------------------------------------------
	always_comb
	begin
		nxt_s = s_ff;
		// Pins: second stage feeds logic; clock and select edges also use the third stage
		nxt_s.sclk = {s_ff.sclk[1:0], serial_clk_i};
		nxt_s.csn  = {s_ff.csn[1:0], chip_sel_n_i};
		nxt_s.din  = {s_ff.din[0], data_line_zero_i};
		nxt_s.vpp  = {s_ff.vpp[0], vpp_high_i};
		sclk_rise = s_ff.sclk[1] & ~s_ff.sclk[2];
		desel     = s_ff.csn[1] & ~s_ff.csn[2];
		wr_rd  = desel && s_ff.bits == BITS_WR
			&& s_ff.shift[15:8] == FVCR_OP_WR_RD;
		wr_enh = desel && s_ff.bits == BITS_WR
			&& s_ff.shift[15:8] == FVCR_OP_WR_ENH;
		clr_fs = desel && s_ff.bits == BITS_CMD
			&& s_ff.shift[7:0] == FVCR_OP_CLR_FS;
		tmo_hit = s_ff.vst == FVCR_VPP_WAIT && s_ff.tmr == TMO_LAST
			&& !s_ff.vpp[1];

		if (s_ff.csn[1])
			nxt_s.bits = 5'h00;
		else if (sclk_rise)
		begin
			nxt_s.shift = {s_ff.shift[14:0], s_ff.din[1]};
			if (s_ff.bits != BITS_SAT)
				nxt_s.bits = s_ff.bits + 5'h01;
		end

		if (!s_ff.loaded)
		begin
			// power-on image restores hold unless cleared
			nxt_s.loaded = 1'b1;
			nxt_s.rd_cfg = {nonvolatile_config_i[15:12],
				nonvolatile_config_i[FVCR_NV_XIP_BIT], 1'b0,
				FVCR_WRAP_SEQ};
			nxt_s.enh_cfg = {nonvolatile_config_i[FVCR_NV_QUAD_BIT],
				nonvolatile_config_i[FVCR_NV_DUAL_BIT], 1'b0,
				nonvolatile_config_i[FVCR_NV_HOLD_BIT], 1'b1,
				nonvolatile_config_i[8:6]};
		end
		else
		begin
			// a completed write replaces the loaded value
			if (wr_rd)
				nxt_s.rd_cfg = s_ff.shift[7:0] & FVCR_RD_MASK;
			if (wr_enh)
				nxt_s.enh_cfg = s_ff.shift[7:0] & FVCR_ENH_MASK;
		end
		// outputs move on the cycle after the write completes
		nxt_s.cfg = cfg_of(nxt_s.rd_cfg, nxt_s.enh_cfg);

		// read address stays inside the aligned block
		// increment with wrap to block start
		if (rd_load_i)
			nxt_s.addr = rd_addr_i;
		else if (rd_step_i)
			nxt_s.addr = wrap_next(s_ff.addr, s_ff.cfg.wrap);

		case (s_ff.vst)
			FVCR_VPP_IDLE:
			begin
				nxt_s.tmr = '0;
				if (quad_modify_done_i && s_ff.cfg.accel_en)
					nxt_s.vst = FVCR_VPP_WAIT;
			end
			FVCR_VPP_WAIT:
			begin
				nxt_s.tmr = s_ff.tmr + 1'b1;
				if (s_ff.vpp[1])
					nxt_s.vst = FVCR_VPP_ACCEL;
				else if (tmo_hit)
					nxt_s.vst = FVCR_VPP_IDLE;
			end
			FVCR_VPP_ACCEL:
			begin
				if (!s_ff.vpp[1])
					nxt_s.vst = FVCR_VPP_IDLE;
			end
			default:
				nxt_s.vst = FVCR_VPP_IDLE;
		endcase
		// in quad protocol, extended commands until the voltage falls back or the wait times out
		nxt_s.ovr = nxt_s.vst != FVCR_VPP_IDLE
			&& nxt_s.cfg.proto == FVCR_PROTO_QUAD;
		// sticky error, a new time-out beats the clear
		nxt_s.err = tmo_hit | (s_ff.err & ~clr_fs);
	end

	always_ff @(posedge clk_sys_i)
	begin
		if (sys_rst_i)
		begin
			s_ff         <= '0;
			s_ff.sclk    <= 3'h0;
			s_ff.csn     <= 3'h7;
			s_ff.rd_cfg  <= FVCR_RD_RST;
			s_ff.enh_cfg <= FVCR_ENH_RST;
			s_ff.cfg     <= cfg_of(FVCR_RD_RST, FVCR_ENH_RST);
			s_ff.vst     <= FVCR_VPP_IDLE;
		end
		else
			s_ff <= nxt_s;
	end

	assign volatile_read_config_o     = s_ff.rd_cfg;
	assign volatile_enhanced_config_o = s_ff.enh_cfg;
	assign cfg_o                      = s_ff.cfg;
	assign ext_override_o             = s_ff.ovr;
	assign vpp_error_o                = s_ff.err;
	assign rd_addr_o                  = s_ff.addr;

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (sys_rst_i);

	sequence s_enh_write;
		wr_enh && s_ff.loaded;
	endsequence

	sequence s_step_16;
		rd_step_i && !rd_load_i && s_ff.cfg.wrap == FVCR_WRAP_16;
	endsequence

	a_dummy_count: assert property (
		s_ff.rd_cfg[7:4] != 4'h0 |-> cfg_o.dummy == s_ff.rd_cfg[7:4])
		else $error("dummy count mismatch");
	a_xip_gate: assert property (
		!BASIC_XIP && s_ff.rd_cfg[FVCR_RD_XIP_BIT] |-> !cfg_o.xip_allowed)
		else $error("xip allowed while disabled");
	a_quad_priority: assert property (
		!s_ff.enh_cfg[FVCR_ENH_QUAD_BIT] |-> cfg_o.proto == FVCR_PROTO_QUAD)
		else $error("quad not selected");
	a_dual_select: assert property (
		s_ff.enh_cfg[7:6] == 2'b10 |-> cfg_o.proto == FVCR_PROTO_DUAL)
		else $error("dual not selected");
	a_ext_resume: assert property (
		s_ff.enh_cfg[7:6] == 2'b11 |-> cfg_o.proto == FVCR_PROTO_EXT)
		else $error("extended not resumed");
	a_write_takes: assert property (
		s_enh_write |=> volatile_enhanced_config_o
			== ($past(s_ff.shift[7:0]) & FVCR_ENH_MASK)
			&& cfg_o.proto == proto_of(volatile_enhanced_config_o))
		else $error("enhanced write not applied");
	a_hold_follow: assert property (
		cfg_o.hold_en == volatile_enhanced_config_o[FVCR_ENH_HOLD_BIT])
		else $error("hold enable mismatch");
	a_accel_gate: assert property (
		s_ff.vst == FVCR_VPP_IDLE && quad_modify_done_i
			&& !cfg_o.accel_en |=> s_ff.vst == FVCR_VPP_IDLE)
		else $error("voltage wait without enable");
	a_wrap_step: assert property (
		s_step_16 |=> rd_addr_o == {$past(rd_addr_o[23:4]),
			$past(rd_addr_o[3:0]) + 4'h1})
		else $error("16-byte wrap step wrong");
	a_err_sticky: assert property (
		vpp_error_o && !clr_fs |=> vpp_error_o)
		else $error("error flag dropped");
	a_reserved_zero: assert property (
		(volatile_read_config_o & ~FVCR_RD_MASK) == 8'h00
		&& (volatile_enhanced_config_o & ~FVCR_ENH_MASK) == 8'h00)
		else $error("reserved bits set");

endmodule

//--- shared/fvcr_pkg.sv
// Purpose: constants and carriers for the volatile configuration block
// Assumes: 8-bit configuration registers, 16-bit non-volatile image
// Notes:   reserved bits are masked off on every write

package fvcr_pkg;

	// ------------------------------------------------------------
	// Register reset values and writable-bit masks
	// ------------------------------------------------------------
	localparam logic [7:0] FVCR_RD_RST   = 8'hfb;
	localparam logic [7:0] FVCR_ENH_RST  = 8'hdf;
	localparam logic [7:0] FVCR_RD_MASK  = 8'hfb;
	localparam logic [7:0] FVCR_ENH_MASK = 8'hdf;

	// ------------------------------------------------------------
	// Field positions
	// ------------------------------------------------------------
	localparam int FVCR_RD_DUMMY_LSB = 4;
	localparam int FVCR_RD_XIP_BIT   = 3;
	localparam int FVCR_ENH_QUAD_BIT = 7;
	localparam int FVCR_ENH_DUAL_BIT = 6;
	localparam int FVCR_ENH_HOLD_BIT = 4;
	localparam int FVCR_ENH_ACC_BIT  = 3;
	localparam int FVCR_NV_DUMMY_LSB = 12;
	localparam int FVCR_NV_XIP_BIT   = 9;
	localparam int FVCR_NV_DRV_LSB   = 6;
	localparam int FVCR_NV_HOLD_BIT  = 4;
	localparam int FVCR_NV_QUAD_BIT  = 3;
	localparam int FVCR_NV_DUAL_BIT  = 2;

	// ------------------------------------------------------------
	// Wrap encodings and dummy count substitute
	// ------------------------------------------------------------
	localparam logic [1:0] FVCR_WRAP_16  = 2'h0;
	localparam logic [1:0] FVCR_WRAP_32  = 2'h1;
	localparam logic [1:0] FVCR_WRAP_64  = 2'h2;
	localparam logic [1:0] FVCR_WRAP_SEQ = 2'h3;
	localparam logic [3:0] FVCR_DUMMY_MAX = 4'hf;

	// ------------------------------------------------------------
	// Serial instruction codes (values arbitrary)
	// ------------------------------------------------------------
	localparam logic [7:0] FVCR_OP_WR_RD  = 8'ha1;
	localparam logic [7:0] FVCR_OP_WR_ENH = 8'ha2;
	localparam logic [7:0] FVCR_OP_CLR_FS = 8'ha3;

	// ------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------
	localparam int FVCR_VPP_TIMEOUT_MS = 200;
	localparam int FVCR_CLK_KHZ        = 20000;
	localparam int FVCR_VPP_TIMEOUT_CYC =
		FVCR_VPP_TIMEOUT_MS * FVCR_CLK_KHZ;

	typedef enum logic [1:0] {
		FVCR_PROTO_EXT  = 2'b00,
		FVCR_PROTO_DUAL = 2'b01,
		FVCR_PROTO_QUAD = 2'b10
	} fvcr_proto_t;

	typedef enum logic [1:0] {
		FVCR_VPP_IDLE  = 2'b00,
		FVCR_VPP_WAIT  = 2'b01,
		FVCR_VPP_ACCEL = 2'b10
	} fvcr_vpp_t;

	typedef struct packed {
		logic [3:0]  dummy;
		logic        xip_allowed;
		logic [1:0]  wrap;
		fvcr_proto_t proto;
		logic        hold_en;
		logic        accel_en;
		logic [2:0]  drive;
	} fvcr_cfg_t;

endpackage

//--- test/fvcr_host_model.sv
// Purpose: serial host that issues configuration instructions
// Assumes: mode 0 framing, msb first, single data line
// Notes:   serial clock stands low between frames

`timescale 1ns/1ps

module fvcr_host_model
(
	input  wire logic clk_i,
	output logic      serial_clk_o,
	output logic      chip_sel_n_o,
	output logic      data_o
);
	initial
	begin
		serial_clk_o = 1'b0;
		chip_sel_n_o = 1'b1;
		data_o       = 1'b1;
	end

	// Four system cycles make half of a 400 ns serial period
	task automatic half_period();
		repeat (4) @(negedge clk_i);
	endtask

	// ------------------------------------------------------------
	// One whole instruction per select
	// ------------------------------------------------------------
	task automatic send(input logic [15:0] word, input int nbits);
		@(negedge clk_i);
		chip_sel_n_o = 1'b0;
		for (int i = 15; i > 15 - nbits; i--)
		begin
			data_o = word[i];
			half_period();
			serial_clk_o = 1'b1;
			half_period();
			serial_clk_o = 1'b0;
		end
		half_period();
		chip_sel_n_o = 1'b1;
		// Released line must not keep showing the last bit
		data_o = ~data_o;
		repeat (8) @(negedge clk_i);
	endtask
endmodule

//--- test/testbench.sv
// Purpose: self-checking bench of the volatile configuration block
// Assumes: host model drives the serial pins
// Notes:   voltage time-out shortened to 50 cycles

`timescale 1ns/1ps

module testbench;
	import fvcr_pkg::*;

	logic        clk = 1'b0;
	logic        rst = 1'b1;
	logic        sclk, cs_n, din;
	logic        vpp = 1'b0, qdone = 1'b0, ld = 1'b0, step = 1'b0;
	logic [23:0] addr = 24'h0;
	logic [7:0]  rd_cfg, enh_cfg;
	fvcr_cfg_t   cfg;
	fvcr_cfg_t   cfg_b;
	logic        ext_ovr, vpp_err;
	logic [23:0] addr_q;
	int          errors = 0;
	int          cmp_count = 0;

	always #25 clk = ~clk;

	fvcr_host_model u_host (.clk_i(clk), .serial_clk_o(sclk),
		.chip_sel_n_o(cs_n), .data_o(din));

	fvcr_regs #(.VPP_TIMEOUT_CYC(50)) u_dut (
		.clk_sys_i(clk), .sys_rst_i(rst), .serial_clk_i(sclk),
		.chip_sel_n_i(cs_n), .data_line_zero_i(din),
		.vpp_high_i(vpp), .nonvolatile_config_i(16'h7fef),
		.quad_modify_done_i(qdone), .rd_load_i(ld), .rd_addr_i(addr),
		.rd_step_i(step), .volatile_read_config_o(rd_cfg),
		.volatile_enhanced_config_o(enh_cfg), .cfg_o(cfg),
		.ext_override_o(ext_ovr), .vpp_error_o(vpp_err),
		.rd_addr_o(addr_q));

	// Basic variant shares all inputs; only its enable is judged
	fvcr_regs #(.BASIC_XIP(1'b1), .VPP_TIMEOUT_CYC(50)) u_dut_basic (
		.clk_sys_i(clk), .sys_rst_i(rst), .serial_clk_i(sclk),
		.chip_sel_n_i(cs_n), .data_line_zero_i(din),
		.vpp_high_i(vpp), .nonvolatile_config_i(16'h7fef),
		.quad_modify_done_i(qdone), .rd_load_i(ld), .rd_addr_i(addr),
		.rd_step_i(step), .volatile_read_config_o(),
		.volatile_enhanced_config_o(), .cfg_o(cfg_b),
		.ext_override_o(), .vpp_error_o(), .rd_addr_o());

	task automatic chk(input string nm, input logic [23:0] seen,
		input logic [23:0] exp);
		cmp_count++;
		if (seen !== exp)
		begin
			errors++;
			$display("FAIL %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic end_sim();
		$display("errors %0d comparisons %0d", errors, cmp_count);
		if (errors == 0 && cmp_count > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	task automatic wr_rd(input logic [7:0] d);
		u_host.send({FVCR_OP_WR_RD, d}, 16);
	endtask

	task automatic wr_enh(input logic [7:0] d);
		u_host.send({FVCR_OP_WR_ENH, d}, 16);
	endtask

	task automatic pulse_done();
		@(negedge clk);
		qdone = 1'b1;
		@(negedge clk);
		qdone = 1'b0;
	endtask

	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	task automatic t_reset();
		repeat (2) @(negedge clk);
		chk("rd rst", rd_cfg, FVCR_RD_RST);
		chk("enh rst", enh_cfg, FVCR_ENH_RST);
		rst = 1'b0;
		repeat (3) @(negedge clk);
		chk("rd nv", rd_cfg, 8'h7b);
		chk("enh nv", enh_cfg, 8'hcf);
		chk("hold nv", cfg.hold_en, 1'b0);
	endtask

	task automatic t_read_cfg();
		wr_rd(8'h07);
		chk("rd w1", rd_cfg, 8'h03);
		chk("dummy 0", cfg.dummy, FVCR_DUMMY_MAX);
		chk("xip on", cfg.xip_allowed, 1'b1);
		wr_rd(8'h5c);
		chk("rd w2", rd_cfg, 8'h58);
		chk("dummy 5", cfg.dummy, 4'h5);
		chk("xip off", cfg.xip_allowed, 1'b0);
		chk("xip basic", cfg_b.xip_allowed, 1'b1);
	endtask

	task automatic t_wrap();
		logic [23:0] m[4];
		logic [23:0] a;
		m = '{24'h00000f, 24'h00001f, 24'h00003f, 24'hffffff};
		for (int w = 0; w < 4; w++)
		begin
			wr_rd(8'h18 | 8'(w));
			chk("wrap", cfg.wrap, 24'(w));
			chk("dummy 1", cfg.dummy, 4'h1);
			addr = 24'h00001f;
			ld = 1'b1;
			@(negedge clk);
			ld = 1'b0;
			step = 1'b1;
			repeat (2) @(negedge clk);
			step = 1'b0;
			a = 24'h00001f;
			repeat (2) a = (a & ~m[w]) | ((a + 24'h1) & m[w]);
			chk("addr", addr_q, a);
		end
	endtask

	task automatic t_proto();
		fvcr_proto_t p;
		for (int i = 0; i < 4; i++)
		begin
			wr_enh({2'(i), 6'h3f});
			p = !i[1] ? FVCR_PROTO_QUAD :
				(!i[0] ? FVCR_PROTO_DUAL : FVCR_PROTO_EXT);
			chk("enh", enh_cfg, {2'(i), 6'h1f});
			chk("proto", cfg.proto, p);
			chk("drive", cfg.drive, 3'h7);
		end
		wr_enh(8'hed);
		chk("hold off", cfg.hold_en, 1'b0);
		chk("drive 5", cfg.drive, 3'h5);
		wr_enh(8'hdf);
		chk("hold on", cfg.hold_en, 1'b1);
	endtask

	task automatic t_accel();
		pulse_done();
		repeat (60) @(negedge clk);
		chk("no accel", vpp_err, 1'b0);
		wr_enh(8'h57);
		chk("accel en", cfg.accel_en, 1'b1);
		pulse_done();
		repeat (4) @(negedge clk);
		chk("ovr wait", ext_ovr, 1'b1);
		repeat (60) @(negedge clk);
		chk("late vpp", vpp_err, 1'b1);
		chk("ovr idle", ext_ovr, 1'b0);
		pulse_done();
		// Outside party raises the voltage in time
		vpp = 1'b1;
		repeat (60) @(negedge clk);
		chk("sticky", vpp_err, 1'b1);
		chk("ovr accel", ext_ovr, 1'b1);
		vpp = 1'b0;
		repeat (5) @(negedge clk);
		chk("ovr end", ext_ovr, 1'b0);
		// Host clears the flag before the next modify
		u_host.send({FVCR_OP_CLR_FS, 8'h00}, 8);
		chk("cleared", vpp_err, 1'b0);
		pulse_done();
		vpp = 1'b1;
		repeat (60) @(negedge clk);
		chk("vpp in time", vpp_err, 1'b0);
		vpp = 1'b0;
		repeat (5) @(negedge clk);
		chk("ovr end 2", ext_ovr, 1'b0);
	endtask

	initial
	begin
		t_reset();
		t_read_cfg();
		t_wrap();
		t_proto();
		t_accel();
		end_sim();
	end

	// Whole run needs about 0.1 ms of serial traffic
	initial
	begin
		#1ms;
		errors++;
		end_sim();
	end
endmodule
